//--- hdl/gpio_ports.v
// Purpose: three 8-bit general-purpose ports with write-only direction registers
// Assumes: sys_clk is the instruction clock; alternate function selects arrive as masks
// Notes: pin reads sample the pads through a three-stage synchroniser
// How it works
// - port reads return pin levels, never the output latch contents
// - direction registers write-only; reset sets all implemented bits, pins input
// - first port eight bits; alternate function pins read as zero
// - second port pull-ups and wake-on-change enabled for whole port only
// - direction-load instruction copies accumulator into selected direction register
// - direction bit one puts output driver into high impedance
// - direction bit zero drives pin from its output latch
// - timer clock select overrides direction bit on timer clock pin
// - master clear and first port pin 3 input only; other pins individually programmable
// - output latches hold value until software writes them again
// - three port data registers eight bits, read and write, undefined at power-on
// - first port priority: analog/oscillator first, clock/analog next, direction last
// - second port programming pins and comparator outputs override digital function
// - first port direction bit three always taken as one, never an output
// - writes reach pins at the end of the cycle after the write; reads sample pins at cycle start
// - bit set and clear read pin levels, modify one bit, write all latches
`include "gpio_map.vh"
`timescale 1ns/1ps
`default_nettype none

module gpio_ports #(
	parameter [7:0] PORT1_IMPL = 8'hFF,
	parameter [7:0] PORT2_IMPL = 8'hFF,
	parameter [7:0] PORT3_IMPL = 8'hFF
) (
	// clock and reset
	input  wire        sys_clk,
	input  wire        arst_n,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// bit set / bit clear instruction
	input  wire        bit_op,
	input  wire        bit_set,
	input  wire [2:0]  bit_sel,
	// direction-load instruction
	input  wire        dir_load,
	input  wire [1:0]  dir_sel,
	input  wire [7:0]  accum,
	// alternate function ownership, one bit per pin
	input  wire [7:0]  port1_prio1_mask,
	input  wire [7:0]  port1_prio2_mask,
	input  wire [7:0]  port2_override_mask,
	input  wire [7:0]  port2_override_out,
	input  wire [7:0]  port2_override_oe,
	input  wire [7:0]  port3_alt_mask,
	// pins
	input  wire [7:0]  port1_in,
	output reg  [7:0]  port1_out,
	output reg  [7:0]  port1_oe,
	input  wire [7:0]  port2_in,
	output reg  [7:0]  port2_out,
	output reg  [7:0]  port2_oe,
	input  wire [7:0]  port3_in,
	output reg  [7:0]  port3_out,
	output reg  [7:0]  port3_oe,
	input  wire        master_clear_pin,
	// second port features and timer clock
	output wire        port2_pullup_en,
	output reg         port2_wake,
	output wire        timer_ext_clock
);

	// output latches (no reset: undefined at power-on)
	reg  [7:0] lat1_q;
	reg  [7:0] lat2_q;
	reg  [7:0] lat3_q;
	// direction registers, written only by the direction-load strobe
	reg  [7:0] dir1_q;
	reg  [7:0] dir2_q;
	reg  [7:0] dir3_q;
	// control bits: pull-up, wake enable, timer clock select
	reg  [7:0] pctl_q;
	// three-stage pin synchronisers, first port
	reg  [7:0] s1a_q;
	reg  [7:0] s1b_q;
	reg  [7:0] s1c_q;
	// second port
	reg  [7:0] s2a_q;
	reg  [7:0] s2b_q;
	reg  [7:0] s2c_q;
	// third port
	reg  [7:0] s3a_q;
	reg  [7:0] s3b_q;
	reg  [7:0] s3c_q;
	// settled pin levels as seen by port reads
	reg  [7:0] lvl1_q;
	reg  [7:0] lvl2_q;
	reg  [7:0] lvl3_q;
	// second port levels one cycle back, for wake-on-change
	reg  [7:0] wake_ref_q;
	// master clear synchroniser and its settled level
	reg        clr_sa_q;
	reg        clr_sb_q;
	reg        clr_sc_q;
	reg        clr_lvl_q;

	// read values and pin ownership
	wire [7:0] rd1;
	wire [7:0] rd2;
	wire [7:0] rd3;
	wire       tck_sel;
	wire [7:0] tck_mask;
	wire [7:0] p1_alt;
	wire [7:0] dir1_eff;

	// replace one bit of a byte
	function [7:0] put_bit;
		input [7:0] v;
		input [2:0] idx;
		input       b;
		reg   [7:0] m;
		begin
			m       = 8'h01 << idx;
			put_bit = b ? (v | m) : (v & ~m);
		end
	endfunction

	// a level counts once stages two and three agree
	// while they differ the previous settled level holds
	function [7:0] settle;
		input [7:0] cur;
		input [7:0] b;
		input [7:0] c;
		begin
			settle = (b & ~(b ^ c)) | (cur & (b ^ c));
		end
	endfunction

	assign tck_sel  = pctl_q[`PCTL_TCKSEL_BIT];
	// timer clock is pin 4 of the first port when selected
	assign tck_mask = tck_sel ? 8'h10 : 8'h00;
	// level 1 and level 2 functions own the pin ahead of direction control
	assign p1_alt   = port1_prio1_mask | port1_prio2_mask | tck_mask;
	// pin 3 forced input
	assign dir1_eff = dir1_q | (8'h01 << `PORT1_INONLY_BIT);

	// port read values: pin levels, alternate pins zero, missing bits zero
	assign rd1 = lvl1_q & ~p1_alt & PORT1_IMPL;
	assign rd2 = lvl2_q & ~port2_override_mask & PORT2_IMPL;
	assign rd3 = lvl3_q & ~port3_alt_mask & PORT3_IMPL;

	assign port2_pullup_en = pctl_q[`PCTL_PULLUP_BIT];
	assign timer_ext_clock = tck_sel & lvl1_q[4];

	// pin synchronisers; reads use the settled level at cycle start
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1a_q     <= 8'h00;
			s1b_q     <= 8'h00;
			s1c_q     <= 8'h00;
			s2a_q     <= 8'h00;
			s2b_q     <= 8'h00;
			s2c_q     <= 8'h00;
			s3a_q     <= 8'h00;
			s3b_q     <= 8'h00;
			s3c_q     <= 8'h00;
			lvl1_q    <= 8'h00;
			lvl2_q    <= 8'h00;
			lvl3_q    <= 8'h00;
			clr_sa_q  <= 1'b0;
			clr_sb_q  <= 1'b0;
			clr_sc_q  <= 1'b0;
			clr_lvl_q <= 1'b0;
		end
		else
		begin
			// only the first stage sees the raw pad
			s1a_q     <= port1_in;
			s1b_q     <= s1a_q;
			s1c_q     <= s1b_q;
			s2a_q     <= port2_in;
			s2b_q     <= s2a_q;
			s2c_q     <= s2b_q;
			s3a_q     <= port3_in;
			s3b_q     <= s3a_q;
			s3c_q     <= s3b_q;
			clr_sa_q  <= master_clear_pin;
			clr_sb_q  <= clr_sa_q;
			clr_sc_q  <= clr_sb_q;
			// master clear level moves only when stages two and three agree
			clr_lvl_q <= (clr_sb_q == clr_sc_q) ? clr_sc_q : clr_lvl_q;
			lvl1_q    <= settle(lvl1_q, s1b_q, s1c_q);
			lvl2_q    <= settle(lvl2_q, s2b_q, s2c_q);
			lvl3_q    <= settle(lvl3_q, s3b_q, s3c_q);
		end
	end

	// output latches: plain writes and read-modify-write bit ops
	always @(posedge sys_clk)
	begin
		if (reg_wr && reg_addr == `PORT1_IDX)
			lat1_q <= reg_wdata & PORT1_IMPL;
		else if (bit_op && reg_addr == `PORT1_IDX)
			lat1_q <= put_bit(rd1, bit_sel, bit_set);
		if (reg_wr && reg_addr == `PORT2_IDX)
			lat2_q <= reg_wdata & PORT2_IMPL;
		else if (bit_op && reg_addr == `PORT2_IDX)
			lat2_q <= put_bit(rd2, bit_sel, bit_set);
		if (reg_wr && reg_addr == `PORT3_IDX)
			lat3_q <= reg_wdata & PORT3_IMPL;
		else if (bit_op && reg_addr == `PORT3_IDX)
			lat3_q <= put_bit(rd3, bit_sel, bit_set);
	end

	// direction registers, loaded only by the direction instruction
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dir1_q <= `DIR_RESET;
			dir2_q <= `DIR_RESET;
			dir3_q <= `DIR_RESET;
		end
		else if (dir_load)
		begin
			case (dir_sel)
				`DIRSEL_PORT1: dir1_q <= accum | ~PORT1_IMPL;
				`DIRSEL_PORT2: dir2_q <= accum | ~PORT2_IMPL;
				`DIRSEL_PORT3: dir3_q <= accum | ~PORT3_IMPL;
				default: dir1_q <= dir1_q;
			endcase
		end
	end

	// control register and whole-port wake-on-change
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pctl_q     <= `PCTL_RESET;
			wake_ref_q <= 8'h00;
			port2_wake <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == `PCTL_IDX)
				pctl_q <= reg_wdata & 8'h07;
			wake_ref_q <= lvl2_q;
			// set wins over the read clear
			if (pctl_q[`PCTL_WAKE_BIT] && (wake_ref_q != lvl2_q))
				port2_wake <= 1'b1;
			else if (reg_rd && reg_addr == `PWAKE_IDX)
				port2_wake <= 1'b0;
		end
	end

	// pad drive: direction zero drives latch, one floats
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port1_oe  <= 8'h00;
			port2_oe  <= 8'h00;
			port3_oe  <= 8'h00;
			port1_out <= 8'h00;
			port2_out <= 8'h00;
			port3_out <= 8'h00;
		end
		else
		begin
			port1_out <= lat1_q;
			port1_oe  <= ~dir1_eff & ~p1_alt & PORT1_IMPL;
			port2_out <= (lat2_q & ~port2_override_mask)
				| (port2_override_out & port2_override_mask);
			port2_oe  <= ((~dir2_q & ~port2_override_mask)
				| (port2_override_oe & port2_override_mask)) & PORT2_IMPL;
			port3_out <= lat3_q;
			port3_oe  <= ~dir3_q & ~port3_alt_mask & PORT3_IMPL;
		end
	end

	// read data one cycle after the strobe; direction registers not readable
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`PORT1_IDX: reg_rdata <= rd1;
				`PORT2_IDX: reg_rdata <= rd2;
				`PORT3_IDX: reg_rdata <= rd3;
				`PCTL_IDX:  reg_rdata <= pctl_q;
				`PWAKE_IDX: reg_rdata <= {6'h00, clr_lvl_q, port2_wake};
				default:    reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

endmodule
`default_nettype wire

//--- hdl/gpio_map.vh
// Purpose: register indices, field positions and reset values for the gpio ports
// Assumes: plain register port, one byte per register index
// Notes: direction registers are not in the data map; they load through a separate strobe
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// port data register indices
`define PORT1_IDX        4'h6
`define PORT2_IDX        4'h7
`define PORT3_IDX        4'h8
// control register of my own: pull-up enable, wake enable, timer clock select
`define PCTL_IDX         4'h9
// wake-on-change status register, read clears
`define PWAKE_IDX        4'hA
`define PCTL_PULLUP_BIT  0
`define PCTL_WAKE_BIT    1
`define PCTL_TCKSEL_BIT  2
`define PCTL_RESET       8'h00
// direction reset: all pins input
`define DIR_RESET        8'hFF
// first port pin 3 is input-only, direction bit forced high
`define PORT1_INONLY_BIT 3
// direction-load port selectors
`define DIRSEL_PORT1     2'h0
`define DIRSEL_PORT2     2'h1
`define DIRSEL_PORT3     2'h2

`endif

//--- dv/pin_loads.sv
// Purpose: outside loads on one 8-bit port
// Assumes: port driver wins over the outside source
// Notes: undriven, unheld pads fall to the pull level
`timescale 1ns/1ps
`default_nettype none
module pin_loads (
	// port drive
	input wire logic [7:0] oe,
	input wire logic [7:0] out,
	// outside source and pull
	input wire logic [7:0] ext,
	input wire logic [7:0] ext_en,
	input wire logic       pull,
	// pad level
	output logic [7:0]     pin
);
	// driver, then held source, else pull level
	assign pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & {8{pull}});
endmodule
`default_nettype wire

//--- dv/gpio_ports_monitor.sv
// Purpose: port-level checks for gpio_ports
// Assumes: masks held steady by the bench
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_monitor (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       arst_n,
	// register port and instruction strobes
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic       bit_op,
	input wire logic       dir_load,
	input wire logic [3:0] reg_addr,
	input wire logic [1:0] dir_sel,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] accum,
	// alternate function ownership
	input wire logic [7:0] port3_alt_mask,
	input wire logic [7:0] port2_override_mask,
	input wire logic [7:0] port2_override_oe,
	// pad drive and second port features
	input wire logic [7:0] port1_oe,
	input wire logic [7:0] port2_oe,
	input wire logic [7:0] port3_oe,
	input wire logic [7:0] port3_out,
	input wire logic       port2_pullup_en
);
	logic busy;
	// any latch or direction update
	assign busy = reg_wr | bit_op | dir_load;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	AST_RESET_IN: assert property ($rose(arst_n) |-> (port1_oe | port3_oe) == 8'h00)
		else $error("oe after reset");
	AST_PIN3_IN: assert property (port1_oe[3] == 1'b0)
		else $error("pin3 driven");
	AST_DIR_LOAD: assert property (dir_load && dir_sel == 2'h2 |->
		##2 port3_oe == (~$past(accum, 2) & ~port3_alt_mask)) else $error("dir load");
	AST_LATCH_OUT: assert property (reg_wr && reg_addr == 4'h8 |->
		##2 ((port3_out ^ $past(reg_wdata, 2)) & port3_oe) == 8'h00) else $error("latch out");
	AST_LATCH_HOLD: assert property ($past(arst_n, 3) && !$past(busy) && !$past(busy, 2) |->
		$stable(port3_out & port3_oe)) else $error("latch hold");
	AST_PULLUP: assert property (reg_wr && reg_addr == 4'h9 |=>
		port2_pullup_en == $past(reg_wdata[0])) else $error("pull-up");
	AST_OVERRIDE: assert property ($past(arst_n) && $stable(port2_override_mask) &&
		$stable(port2_override_oe) |->
		((port2_oe ^ port2_override_oe) & port2_override_mask) == 8'h00) else $error("override");
	AST_UNMAPPED: assert property (reg_rd && reg_addr == 4'hF |=> reg_rdata == 8'h00)
		else $error("unmapped");
endmodule
bind gpio_ports gpio_ports_monitor mon (.*);
`default_nettype wire

//--- dv/testbench.sv
// Purpose: self-checking bench for gpio_ports
// Assumes: pin_loads stands in for the board
// Notes: reads wait six cycles for the pin synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map.vh"
module testbench;
	logic       sys_clk, arst_n, reg_wr, reg_rd, bit_op, bit_set, dir_load, master_clear_pin;
	logic       port2_pullup_en, port2_wake, timer_ext_clock;
	logic [3:0] reg_addr;
	logic [2:0] bit_sel;
	logic [1:0] dir_sel;
	logic [7:0] reg_wdata, reg_rdata, accum, port1_prio1_mask, port1_prio2_mask, port3_alt_mask;
	logic [7:0] port2_override_mask, port2_override_out, port2_override_oe, x2, xe2, x1, x3;
	logic [7:0] port1_in, port1_out, port1_oe, port2_in, port2_out, port2_oe;
	logic [7:0] port3_in, port3_out, port3_oe;
	int         n_errors, checked;
	gpio_ports dut (.*);
	pin_loads ld1 (.oe(port1_oe), .out(port1_out), .ext(x1), .ext_en(8'hFF),
		.pull(1'b0), .pin(port1_in));
	pin_loads ld2 (.oe(port2_oe), .out(port2_out), .ext(x2), .ext_en(xe2),
		.pull(port2_pullup_en), .pin(port2_in));
	pin_loads ld3 (.oe(port3_oe), .out(port3_out), .ext(x3), .ext_en(8'hFF),
		.pull(1'b0), .pin(port3_in));
	// clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e, string n);
		repeat (6) @(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask
	task automatic dl(logic [1:0] s, logic [7:0] v);
		@(posedge sys_clk);
		dir_sel <= s;
		accum <= v;
		dir_load <= 1'b1;
		@(posedge sys_clk);
		dir_load <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic t_drive;
		wr(`PORT3_IDX, 8'h3C);
		dl(2'h2, 8'h0F);
		chk("oe3", 8'hF0, port3_oe);
		rd(`PORT3_IDX, 8'h35, "mix");
		@(posedge sys_clk);
		bit_set <= 1'b1;
		bit_sel <= 3'h7;
		bit_op <= 1'b1;
		@(posedge sys_clk);
		bit_op <= 1'b0;
		dl(2'h2, 8'h00);
		chk("rmw", 8'hB5, port3_out);
		$display("drive done");
	endtask
	task automatic t_alt;
		@(posedge sys_clk);
		port1_prio1_mask <= 8'h81;
		wr(`PORT1_IDX, 8'h5A);
		rd(`PORT1_IDX, 8'h7E, "alt");
		dl(2'h0, 8'h00);
		chk("oe1", 8'h76, port1_oe);
		$display("alt done");
	endtask
	task automatic t_pull;
		@(posedge sys_clk);
		xe2 <= 8'h00;
		wr(`PCTL_IDX, 8'h01);
		rd(`PORT2_IDX, 8'hEF, "pull");
		rd(4'hF, 8'h00, "none");
		chk("hold", 8'hB5, port3_out);
		$display("pull done");
	endtask
	task automatic t_wake;
		wr(`PORT2_IDX, 8'h3C);
		wr(`PCTL_IDX, 8'h03);
		xe2 <= 8'h01;
		repeat (6) @(posedge sys_clk);
		#1 chk("wake", 8'h01, {7'h00, port2_wake});
		chk("out2", 8'h2C, port2_out);
		rd(`PWAKE_IDX, 8'h03, "wake flag");
		rd(`PWAKE_IDX, 8'h02, "wake clear");
		$display("wake done");
	endtask
	task automatic t_timer;
		wr(`PCTL_IDX, 8'h05);
		x1 <= 8'hEF;
		repeat (6) @(posedge sys_clk);
		#1 chk("oe1 tck", 8'h66, port1_oe);
		chk("tck low", 8'h00, {7'h00, timer_ext_clock});
		chk("out1", 8'h5A, port1_out);
		x1 <= 8'hFF;
		rd(`PORT1_IDX, 8'h4A, "tck pins");
		chk("tck high", 8'h01, {7'h00, timer_ext_clock});
		$display("timer done");
	endtask
	task automatic t_reset;
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 chk("oe3 reset", 8'h00, port3_oe);
		chk("latch kept", 8'hB5, port3_out);
		rd(`PCTL_IDX, 8'h00, "ctl reset");
		$display("second reset done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog
	initial
	begin
		repeat (3000) @(posedge sys_clk);
		n_errors++;
		close_out;
	end
	// main sequence
	initial
	begin
		{arst_n, reg_wr, reg_rd, bit_op, bit_set, dir_load} = 6'h00;
		{reg_addr, bit_sel, dir_sel, reg_wdata, accum} = 25'h0;
		{port1_prio1_mask, port1_prio2_mask, port3_alt_mask, port2_override_out} = 32'h0;
		{port2_override_mask, port2_override_oe, x2, xe2} = 32'h101000FF;
		{master_clear_pin, n_errors, checked} = {1'b1, 64'h0};
		{x1, x3} = 16'hFFA5;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		#1 chk("oe", 8'h00, port1_oe | port3_oe);
		rd(`PORT3_IDX, 8'hA5, "pins");
		$display("reset done");
		t_drive;
		t_alt;
		t_pull;
		t_wake;
		t_timer;
		t_reset;
		close_out;
	end
endmodule
`default_nettype wire
